// ### design/cpu_instr_exec_subset.sv
`timescale 1ns/100ps
// Summary of operation
// - power-down instruction clears the power-down status flag
// - power-down instruction sets the time-out status flag
// - power-down instruction zeroes watchdog counter and its prescaler
// - after power-down the core sleeps with oscillator halted, no operands
// - return pops the stack into the program counter, flags unchanged
// - return takes two instruction cycles
// - rotate right through carry; only carry changes; file address 0..127
// - destination bit 0 writes accumulator, 1 writes file register
// - literal minus accumulator, two's complement, result in accumulator
// - file register minus accumulator, two's complement, address 0..127
module cpu_instr_exec_subset
  import exec_subset_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // instruction stream
  input wire logic instr_valid_in,
  input wire logic [2:0] opcode_in,
  input wire logic [7:0] literal_in,
  input wire logic [6:0] file_addr_in,
  input wire logic dest_in,
  output logic busy_out,
  // register file read port, combinational read
  output logic [6:0] file_raddr_out,
  input wire logic [7:0] file_rdata_in,
  // register file write port
  output logic file_we_out,
  output logic [6:0] file_waddr_out,
  output logic [7:0] file_wdata_out,
  // stack
  input wire logic [12:0] stack_top_in,
  output logic stack_pop_out,
  // wake from sleep
  input wire logic wake_in,
  // architectural state
  output logic [7:0] acc_out,
  output logic [12:0] program_counter_out,
  output logic carry_flag_out,
  output logic digit_carry_flag_out,
  output logic zero_flag_out,
  output logic timeout_flag_n_out,
  output logic powerdown_flag_n_out,
  output logic [7:0] watchdog_counter_out,
  output logic [7:0] watchdog_prescaler_out,
  output logic sleep_out,
  output logic osc_enable_out
);

  typedef enum logic [1:0] {RUN, RET_WAIT, ASLEEP} state_t;
  state_t state;

  // subtract a - b: {carry(not borrow), digit carry, result}
  function automatic logic [9:0] sub8(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[NIB-1:0]} + {1'b0, ~b[NIB-1:0]} + 5'h01;
    sub8 = {full[DATA_W], low[NIB], full[MSB:0]};
  endfunction

  logic take;
  logic [9:0] sub_res;
  logic [7:0] rot_res;
  logic [7:0] result;

  // new instructions only accepted while running
  assign take = instr_valid_in && state == RUN;
  assign busy_out = state != RUN;
  assign file_raddr_out = file_addr_in;

  // operand path for the data instructions
  always_comb
  begin
    sub_res = (opcode_in == OP_SUB_LIT) ? sub8(literal_in, acc_out)
                                        : sub8(file_rdata_in, acc_out);
    rot_res = {carry_flag_out, file_rdata_in[MSB:1]};
    result = (opcode_in == OP_ROTATE) ? rot_res : sub_res[MSB:0];
  end

  // sequencing: return stall and sleep
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= RUN;
    else
      case (state)
        RUN:
        begin
          if (take && opcode_in == OP_RETURN)
            state <= RET_WAIT;
          else if (take && opcode_in == OP_SLEEP)
            state <= ASLEEP;
        end
        RET_WAIT: state <= RUN;
        ASLEEP:
        begin
          if (wake_in)
            state <= RUN;
        end
        default: state <= RUN;
      endcase
  end

  assign sleep_out = state == ASLEEP;
  assign osc_enable_out = state != ASLEEP;

  // program counter: return loads stack top, others step by one
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      program_counter_out <= PC_RESET;
    else if (take && opcode_in == OP_RETURN)
      program_counter_out <= stack_top_in;
    else if (take)
      program_counter_out <= program_counter_out + 13'h0001;
  end

  // stack pop pulse, one cycle with the return
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      stack_pop_out <= 1'b0;
    else
      stack_pop_out <= take && opcode_in == OP_RETURN;
  end

  // accumulator
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      acc_out <= ACC_RESET;
    else if (take && opcode_in == OP_SUB_LIT)
      acc_out <= sub_res[MSB:0];
    else if (take && dest_in == DEST_ACC &&
             (opcode_in == OP_ROTATE || opcode_in == OP_SUB_FILE))
      acc_out <= result;
  end

  // file register write back
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      file_we_out <= 1'b0;
      file_waddr_out <= 7'h00;
      file_wdata_out <= 8'h00;
    end
    else
    begin
      file_we_out <= take && dest_in == DEST_FILE &&
        (opcode_in == OP_ROTATE || opcode_in == OP_SUB_FILE);
      file_waddr_out <= file_addr_in;
      file_wdata_out <= result;
    end
  end

  // arithmetic flags; return and sleep leave them alone
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      carry_flag_out <= 1'b0;
      digit_carry_flag_out <= 1'b0;
      zero_flag_out <= 1'b0;
    end
    else if (take && opcode_in == OP_ROTATE)
      carry_flag_out <= file_rdata_in[LSB];
    else if (take && (opcode_in == OP_SUB_LIT ||
                      opcode_in == OP_SUB_FILE))
    begin
      carry_flag_out <= sub_res[DATA_W+1];
      digit_carry_flag_out <= sub_res[DATA_W];
      zero_flag_out <= sub_res[MSB:0] == 8'h00;
    end
  end

  // status bits; reset state is a fresh power-up
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      timeout_flag_n_out <= 1'b1;
      powerdown_flag_n_out <= 1'b1;
    end
    else if (take && opcode_in == OP_SLEEP)
    begin
      powerdown_flag_n_out <= 1'b0;
      timeout_flag_n_out <= 1'b1;
    end
  end

  // watchdog: cleared by sleep, otherwise counts while oscillator runs;
  // the counter wraps freely; nothing sets the time-out flag on a wrap
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      watchdog_counter_out <= WDT_CLEAR;
      watchdog_prescaler_out <= PRE_CLEAR;
    end
    else if (take && opcode_in == OP_SLEEP)
    begin
      watchdog_counter_out <= WDT_CLEAR;
      watchdog_prescaler_out <= PRE_CLEAR;
    end
    else if (state != ASLEEP)
    begin
      watchdog_prescaler_out <= watchdog_prescaler_out + 8'h01;
      if (watchdog_prescaler_out == PRE_LAST)
        watchdog_counter_out <= watchdog_counter_out + 8'h01;
    end
  end

  // checks
  property p_pd_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SLEEP |=> !powerdown_flag_n_out;
  endproperty
  a_pd_clear: assert property (p_pd_clear)
    else $error("power-down flag not cleared by sleep");

  property p_to_set;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SLEEP |=> timeout_flag_n_out;
  endproperty
  a_to_set: assert property (p_to_set)
    else $error("time-out flag not set by sleep");

  property p_wdt_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SLEEP |=>
      watchdog_counter_out == WDT_CLEAR &&
      watchdog_prescaler_out == PRE_CLEAR;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog not cleared by sleep");

  property p_sleep_osc;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SLEEP |=>
      sleep_out && !osc_enable_out ##1 (sleep_out || $past(wake_in));
  endproperty
  a_sleep_osc: assert property (p_sleep_osc)
    else $error("sleep did not halt the oscillator");

  property p_ret_pc;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_RETURN |=>
      program_counter_out == $past(stack_top_in) && stack_pop_out &&
      $stable(carry_flag_out) && $stable(zero_flag_out);
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return did not load stack top");

  property p_ret_two;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_RETURN |=> busy_out ##1 !busy_out;
  endproperty
  a_ret_two: assert property (p_ret_two)
    else $error("return not two cycles");

  property p_rot;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_ROTATE && dest_in == DEST_ACC |=>
      acc_out == {$past(carry_flag_out), $past(file_rdata_in[MSB:1])} &&
      carry_flag_out == $past(file_rdata_in[LSB]) &&
      $stable(zero_flag_out);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate result wrong");

  property p_dest_file;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SUB_FILE && dest_in == DEST_FILE |=>
      file_we_out && $stable(acc_out) &&
      file_waddr_out == $past(file_addr_in);
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not written");

  property p_sublit;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SUB_LIT |=>
      acc_out == 8'($past(literal_in) - $past(acc_out)) && !file_we_out;
  endproperty
  a_sublit: assert property (p_sublit)
    else $error("literal subtract wrong");

  property p_subfile;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SUB_FILE && dest_in == DEST_FILE |=>
      file_wdata_out == 8'($past(file_rdata_in) - $past(acc_out));
  endproperty
  a_subfile: assert property (p_subfile)
    else $error("file subtract wrong");

  property p_sub_flags;
    @(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SUB_LIT |=>
      carry_flag_out == ($past(literal_in) >= $past(acc_out)) &&
      digit_carry_flag_out ==
        ($past(literal_in[NIB-1:0]) >= $past(acc_out[NIB-1:0])) &&
      zero_flag_out == ($past(literal_in) == $past(acc_out));
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("subtract flags wrong");

  c_sleep: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SLEEP ##[1:20] wake_in);
  c_ret: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_RETURN);
  c_borrow: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_SUB_FILE ##1 !carry_flag_out);
  c_rot_file: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    take && opcode_in == OP_ROTATE && dest_in == DEST_FILE);

endmodule

// ### design/exec_subset_pkg.sv
package exec_subset_pkg;
  // opcode selector presented with each instruction strobe
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SLEEP = 3'h1;
  localparam logic [2:0] OP_RETURN = 3'h2;
  localparam logic [2:0] OP_ROTATE = 3'h3;
  localparam logic [2:0] OP_SUB_LIT = 3'h4;
  localparam logic [2:0] OP_SUB_FILE = 3'h5;
  // operand widths and reset values
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  // bit positions used by the arithmetic
  localparam int MSB = 7;
  localparam int NIB = 4;
  localparam int LSB = 0;
  // prescaler value on which the watchdog counter steps
  localparam logic [7:0] PRE_LAST = 8'hFF;
  // destination select values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // a return occupies two instruction cycles
  localparam int RETURN_CYCLES = 2;
endpackage

// ### verification/cpu_instr_exec_subset_test.sv
`timescale 1ns/100ps
module cpu_instr_exec_subset_test;
  import exec_subset_pkg::*;
  // stimulus driven into the core
  logic clk_in, reset_n_in, instr_valid_in, dest_in, wake_in;
  logic [2:0] opcode_in;
  logic [7:0] literal_in;
  logic [6:0] file_addr_in;
  logic [12:0] stack_top_in;
  logic [7:0] file_rdata_in;
  // outputs observed from the core
  logic busy_out, file_we_out, stack_pop_out, carry_flag_out;
  logic digit_carry_flag_out, zero_flag_out, timeout_flag_n_out;
  logic powerdown_flag_n_out, sleep_out, osc_enable_out;
  logic [6:0] file_raddr_out, file_waddr_out;
  logic [7:0] file_wdata_out, acc_out;
  logic [7:0] watchdog_counter_out, watchdog_prescaler_out;
  logic [12:0] program_counter_out;
  // reference state; the bench owns the file and stores expected results
  logic [7:0] mem [128];
  logic [7:0] m_acc;
  logic [12:0] m_pc;
  logic m_c, m_dc, m_z;
  int n_fail, compares;

  // register file read is combinational, as the core expects
  assign file_rdata_in = mem[file_raddr_out];

  cpu_instr_exec_subset cpu_instr_exec_subset_inst (
    .clk_in, .reset_n_in, .instr_valid_in, .opcode_in, .literal_in,
    .file_addr_in, .dest_in, .busy_out, .file_raddr_out, .file_rdata_in,
    .file_we_out, .file_waddr_out, .file_wdata_out, .stack_top_in,
    .stack_pop_out, .wake_in, .acc_out, .program_counter_out,
    .carry_flag_out, .digit_carry_flag_out, .zero_flag_out,
    .timeout_flag_n_out, .powerdown_flag_n_out, .watchdog_counter_out,
    .watchdog_prescaler_out, .sleep_out, .osc_enable_out
  );

  // 20 MHz instruction clock
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic cmp(input string what, input logic [12:0] exp,
                     input logic [12:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // architectural state against the model
  task automatic check_state;
    cmp("acc", m_acc, acc_out);
    cmp("pc", m_pc, program_counter_out);
    cmp("carry", m_c, carry_flag_out);
    cmp("digit_carry", m_dc, digit_carry_flag_out);
    cmp("zero", m_z, zero_flag_out);
  endtask

  // leaves valid high so that the next call can follow back to back
  task automatic issue(input logic [2:0] op, input logic [7:0] lit,
                       input logic [6:0] addr, input logic d);
    logic [7:0] f, a, res;
    logic we;
    f = mem[addr];
    we = 1'b0;
    res = 8'h00;
    instr_valid_in <= 1'b1;
    opcode_in <= op;
    literal_in <= lit;
    file_addr_in <= addr;
    dest_in <= d;
    if (op == OP_ROTATE)
    begin
      res = {m_c, f[7:1]};
      m_c = f[0];
    end
    else
    begin
      a = (op == OP_SUB_LIT) ? lit : f;
      res = a - m_acc;
      m_c = (a >= m_acc);
      m_dc = (a[3:0] >= m_acc[3:0]);
      m_z = (res == 8'h00);
    end
    if (op == OP_SUB_LIT || d == DEST_ACC)
      m_acc = res;
    else
      we = 1'b1;
    m_pc = m_pc + 13'h0001;
    @(posedge clk_in);
    #1;
    cmp("file_we", we, file_we_out);
    if (we)
    begin
      cmp("file_waddr", addr, file_waddr_out);
      cmp("file_wdata", res, file_wdata_out);
      mem[addr] = res;
    end
    check_state;
  endtask

  // return with valid still high through the dead cycle, which is refused
  task automatic do_return;
    logic [12:0] t;
    t = 13'($urandom);
    stack_top_in <= t;
    instr_valid_in <= 1'b1;
    opcode_in <= OP_RETURN;
    m_pc = t;
    @(posedge clk_in);
    #1;
    cmp("stack_pop", 1'b1, stack_pop_out);
    cmp("busy", 1'b1, busy_out);
    check_state;
    // a wrongly taken second return would now load a different value
    stack_top_in <= ~t;
    @(posedge clk_in);
    #1;
    cmp("stack_pop", 1'b0, stack_pop_out);
    cmp("busy", 1'b0, busy_out);
    check_state;
  endtask

  task automatic do_sleep;
    instr_valid_in <= 1'b1;
    opcode_in <= OP_SLEEP;
    m_pc = m_pc + 13'h0001;
    @(posedge clk_in);
    #1;
    cmp("powerdown_n", 1'b0, powerdown_flag_n_out);
    cmp("timeout_n", 1'b1, timeout_flag_n_out);
    cmp("watchdog", WDT_CLEAR, watchdog_counter_out);
    cmp("prescaler", PRE_CLEAR, watchdog_prescaler_out);
    cmp("sleep", 1'b1, sleep_out);
    cmp("osc", 1'b0, osc_enable_out);
    opcode_in <= OP_SUB_LIT;
    repeat (3) @(posedge clk_in);
    #1;
    check_state;
    // with the oscillator halted the watchdog chain must not move
    cmp("prescaler", PRE_CLEAR, watchdog_prescaler_out);
    cmp("watchdog", WDT_CLEAR, watchdog_counter_out);
    instr_valid_in <= 1'b0;
    wake_in <= 1'b1;
    @(posedge clk_in);
    #1;
    wake_in <= 1'b0;
    cmp("sleep", 1'b0, sleep_out);
    cmp("osc", 1'b1, osc_enable_out);
  endtask

  // a hung run still reaches the verdict
  initial
  begin
    #1000000;
    n_fail++;
    wrap_up;
  end

  // main sequence: reset, boundaries, random mix, returns, sleep
  initial
  begin
    reset_n_in = 1'b0;
    instr_valid_in = 1'b0;
    opcode_in = OP_NONE;
    literal_in = 8'h00;
    file_addr_in = 7'h00;
    dest_in = 1'b0;
    stack_top_in = 13'h0000;
    wake_in = 1'b0;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'hF77D));
    for (int i = 0; i < 128; i++)
      mem[i] = 8'($urandom);
    m_acc = ACC_RESET;
    m_pc = PC_RESET;
    {m_c, m_dc, m_z} = 3'h0;
    repeat (11) @(posedge clk_in);
    #1;
    check_state;
    cmp("timeout_n", 1'b1, timeout_flag_n_out);
    cmp("powerdown_n", 1'b1, powerdown_flag_n_out);
    cmp("busy", 1'b0, busy_out);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    issue(OP_SUB_LIT, 8'hFF, 7'h00, DEST_ACC);
    issue(OP_SUB_FILE, 8'h00, 7'h7F, DEST_FILE);
    issue(OP_SUB_LIT, m_acc, 7'h00, DEST_FILE);
    issue(OP_ROTATE, 8'h00, 7'h7F, DEST_ACC);
    issue(OP_ROTATE, 8'h00, 7'h00, DEST_FILE);
    // random mix, back to back; long enough that the watchdog counter
    // has stepped before sleep, so its clear can be seen
    repeat (300)
      issue(3'(3 + $urandom_range(2)), 8'($urandom), 7'($urandom),
            1'($urandom));
    repeat (4)
    begin
      do_return;
      issue(OP_SUB_FILE, 8'h00, 7'($urandom), 1'($urandom));
    end
    do_sleep;
    issue(OP_SUB_LIT, 8'h00, 7'h00, DEST_ACC);
    instr_valid_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check_state;
    wrap_up;
  end
endmodule
